// ### design/independent_watchdog.sv
`timescale 1ns/1ps
module independent_watchdog (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_dedicated_watchdog_clock,
    input wire logic [2:0] i_opt_div_sel,
    input wire logic [1:0] i_opt_timeout_sel,
    input wire logic [1:0] i_opt_win_start_sel,
    input wire logic [1:0] i_opt_win_end_sel,
    input wire logic i_opt_nmi_select,
    input wire logic i_opt_low_power_stop,
    input wire logic i_low_power_mode,
    input wire logic i_refresh,
    output logic [13:0] o_counter,
    output logic o_running,
    output logic o_underflow_flag,
    output logic o_refresh_error_flag,
    output logic o_reset_request,
    output logic o_nmi_request,
    output logic o_event_pulse
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    prescale_if pif ();

    logic [wdt_pkg::DIV_SEL_W-1:0] div_sel_reg;
    logic [wdt_pkg::CNT_W-1:0] top_reg;
    logic [wdt_pkg::CNT_W-1:0] win_start_reg;
    logic [wdt_pkg::CNT_W-1:0] win_end_reg;
    logic nmi_sel_reg;
    logic lp_stop_reg;
    logic [wdt_pkg::CNT_W-1:0] cnt_reg;
    logic running_reg;
    logic underflow_reg;
    logic refresh_err_reg;
    logic reset_req_reg;
    logic nmi_req_reg;
    logic event_reg;

    logic hold;
    logic in_window;
    logic refresh_ok;
    logic refresh_bad;
    logic underflow;
    logic fault;
    logic count_step;

    // ------------------------------------------------------------
    // Initialisation options
    // ------------------------------------------------------------
    // Options are caught while reset is held and stay frozen afterwards, so software cannot
    // weaken the watchdog once it runs.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            div_sel_reg <= i_opt_div_sel;
            top_reg <= wdt_pkg::timeout_top(i_opt_timeout_sel);
            win_start_reg <= wdt_pkg::window_point(wdt_pkg::timeout_top(i_opt_timeout_sel),
                3'h4 - {1'b0, i_opt_win_start_sel}, 1'b1);
            win_end_reg <= wdt_pkg::window_point(wdt_pkg::timeout_top(i_opt_timeout_sel),
                {1'b0, i_opt_win_end_sel}, 1'b0);
            nmi_sel_reg <= i_opt_nmi_select;
            lp_stop_reg <= i_opt_low_power_stop;
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    assign hold = lp_stop_reg & i_low_power_mode;
    assign pif.div_sel = div_sel_reg;
    assign pif.run = running_reg & ~hold;

    watchdog_prescaler u_prescaler (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_dedicated_watchdog_clock(i_dedicated_watchdog_clock),
        .pif(pif)
    );

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    assign in_window = (cnt_reg <= win_start_reg) && (cnt_reg >= win_end_reg);
    assign refresh_ok = i_refresh & running_reg & in_window;
    assign refresh_bad = i_refresh & running_reg & ~in_window;
    assign count_step = running_reg & pif.tick & ~hold;
    // A valid refresh on the zero tick reloads instead, so it must not also count as a fault
    assign underflow = count_step & (cnt_reg == '0) & ~refresh_ok;
    assign fault = underflow | refresh_bad;

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    // A refresh in the same cycle as a tick wins, giving the full period after it.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cnt_reg <= wdt_pkg::timeout_top(i_opt_timeout_sel);
        end else if (refresh_ok) begin
            cnt_reg <= top_reg;
        end else if (count_step && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 14'h0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            running_reg <= 1'b1;
        end else if (fault) begin
            running_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Response and event outputs
    // ------------------------------------------------------------
    // Flags are cleared only by reset, so there is no set/clear race.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            underflow_reg <= 1'b0;
            refresh_err_reg <= 1'b0;
            reset_req_reg <= 1'b0;
            nmi_req_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            underflow_reg <= underflow_reg | underflow;
            refresh_err_reg <= refresh_err_reg | refresh_bad;
            reset_req_reg <= reset_req_reg | (fault & ~nmi_sel_reg);
            nmi_req_reg <= nmi_req_reg | (fault & nmi_sel_reg);
            event_reg <= fault;
        end
    end

    assign o_counter = cnt_reg;
    assign o_running = running_reg;
    assign o_underflow_flag = underflow_reg;
    assign o_refresh_error_flag = refresh_err_reg;
    assign o_reset_request = reset_req_reg;
    assign o_nmi_request = nmi_req_reg;
    assign o_event_pulse = event_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking

    a_counter_decrement: assert property (disable iff (!i_resetn)
        count_step && !refresh_ok && cnt_reg != '0 |=> cnt_reg == $past(cnt_reg) - 14'h0001)
        else $error("counter did not step down by one");

    a_auto_start: assert property (
        !i_resetn ##1 i_resetn |-> running_reg && cnt_reg == top_reg)
        else $error("watchdog did not start after reset");

    a_reset_restore: assert property (
        !i_resetn |=> cnt_reg == wdt_pkg::timeout_top($past(i_opt_timeout_sel))
        && !o_reset_request && !o_nmi_request && !o_event_pulse)
        else $error("reset did not restore initial values");

    a_low_power_hold: assert property (disable iff (!i_resetn)
        hold && !i_refresh |=> cnt_reg == $past(cnt_reg))
        else $error("counter moved during low-power hold");

    a_fault_stops: assert property (disable iff (!i_resetn)
        fault |=> !running_reg ##1 (!running_reg && cnt_reg == $past(cnt_reg)))
        else $error("counter kept running after a fault");

    a_response_select: assert property (disable iff (!i_resetn)
        fault && !o_reset_request && !o_nmi_request
        |=> (o_nmi_request == nmi_sel_reg) && (o_reset_request == !nmi_sel_reg))
        else $error("wrong response to a fault");

    a_event_output: assert property (disable iff (!i_resetn)
        fault |=> o_event_pulse ##1 !o_event_pulse)
        else $error("event pulse missing or too long");

    a_window_error: assert property (disable iff (!i_resetn)
        i_refresh && running_reg && (cnt_reg > win_start_reg || cnt_reg < win_end_reg)
        |=> o_refresh_error_flag && !running_reg)
        else $error("out-of-window refresh not flagged");

    a_refresh_reload: assert property (disable iff (!i_resetn)
        refresh_ok |=> cnt_reg == top_reg && running_reg && !o_event_pulse)
        else $error("valid refresh did not reload the counter");

    a_count_only_on_tick: assert property (disable iff (!i_resetn)
        !count_step && !refresh_ok |=> cnt_reg == $past(cnt_reg))
        else $error("counter moved without a prescaler tick");

    a_halt_drops_tick: assert property (disable iff (!i_resetn)
        hold |=> !pif.tick)
        else $error("prescaler ticked during low-power hold");

    a_refused_refresh: assert property (disable iff (!i_resetn)
        i_refresh && !running_reg |=> cnt_reg == $past(cnt_reg) && !running_reg)
        else $error("refresh acted on a stopped counter");

    a_underflow_stop: assert property (disable iff (!i_resetn)
        underflow |=> o_underflow_flag && !o_running && o_counter == '0)
        else $error("underflow not flagged or counter still running");

    a_single_response: assert property (disable iff (!i_resetn)
        !(o_reset_request && o_nmi_request))
        else $error("reset and NMI requested together");

    c_underflow: cover property (disable iff (!i_resetn) underflow);
    c_good_refresh: cover property (disable iff (!i_resetn) refresh_ok ##[1:100] count_step);
    c_bad_refresh: cover property (disable iff (!i_resetn) refresh_bad);
    c_low_power: cover property (disable iff (!i_resetn) hold && running_reg);
    c_nmi_response: cover property (disable iff (!i_resetn) fault && nmi_sel_reg);

endmodule : independent_watchdog

// ### design/wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W = 14;
    localparam int DIV_SEL_W = 3;
    localparam int DIV_CNT_W = 8;
    localparam int TOUT_SEL_W = 2;
    localparam int WIN_SEL_W = 2;

    // ------------------------------------------------------------
    // Division ratio codes (ratio minus one per code)
    // ------------------------------------------------------------
    localparam logic [DIV_SEL_W-1:0] DIV_16 = 3'h0;
    localparam logic [DIV_SEL_W-1:0] DIV_32 = 3'h1;
    localparam logic [DIV_SEL_W-1:0] DIV_64 = 3'h2;
    localparam logic [DIV_SEL_W-1:0] DIV_128 = 3'h3;
    localparam logic [DIV_SEL_W-1:0] DIV_256 = 3'h4;
    localparam logic [DIV_CNT_W-1:0] DIV_16_M1 = 8'h0F;
    localparam logic [DIV_CNT_W-1:0] DIV_32_M1 = 8'h1F;
    localparam logic [DIV_CNT_W-1:0] DIV_64_M1 = 8'h3F;
    localparam logic [DIV_CNT_W-1:0] DIV_128_M1 = 8'h7F;
    localparam logic [DIV_CNT_W-1:0] DIV_256_M1 = 8'hFF;

    // ------------------------------------------------------------
    // Timeout reload values, in prescaled ticks minus one
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] TOUT_TOP_0 = 14'h03FF;
    localparam logic [CNT_W-1:0] TOUT_TOP_1 = 14'h0FFF;
    localparam logic [CNT_W-1:0] TOUT_TOP_2 = 14'h1FFF;
    localparam logic [CNT_W-1:0] TOUT_TOP_3 = 14'h3FFF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DIV_CNT_W-1:0] DIV_CNT_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    function automatic logic [DIV_CNT_W-1:0] div_ratio_m1(input logic [DIV_SEL_W-1:0] sel);
        case (sel)
            DIV_16: div_ratio_m1 = DIV_16_M1;
            DIV_32: div_ratio_m1 = DIV_32_M1;
            DIV_64: div_ratio_m1 = DIV_64_M1;
            DIV_128: div_ratio_m1 = DIV_128_M1;
            default: div_ratio_m1 = DIV_256_M1;
        endcase
    endfunction : div_ratio_m1

    function automatic logic [CNT_W-1:0] timeout_top(input logic [TOUT_SEL_W-1:0] sel);
        case (sel)
            2'h0: timeout_top = TOUT_TOP_0;
            2'h1: timeout_top = TOUT_TOP_1;
            2'h2: timeout_top = TOUT_TOP_2;
            default: timeout_top = TOUT_TOP_3;
        endcase
    endfunction : timeout_top

    // Quarter points of the period: q quarters, optionally minus one
    function automatic logic [CNT_W-1:0] window_point(input logic [CNT_W-1:0] top,
                                                      input logic [2:0] q,
                                                      input logic sub1);
        logic [CNT_W:0] quarter;
        logic [CNT_W+3:0] prod;
        quarter = ({1'b0, top} + 15'h0001) >> 2;
        prod = {3'h0, quarter} * {15'h0000, q};
        prod = prod - {17'h00000, sub1};
        window_point = prod[CNT_W-1:0];
    endfunction : window_point

endpackage : wdt_pkg

// ### design/prescale_if.sv
`timescale 1ns/1ps
interface prescale_if;
    logic [wdt_pkg::DIV_SEL_W-1:0] div_sel;
    logic run;
    logic tick;

    modport ctrl (output div_sel, output run, input tick);
    modport divider (input div_sel, input run, output tick);
endinterface : prescale_if

// ### design/watchdog_prescaler.sv
`timescale 1ns/1ps
module watchdog_prescaler (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_dedicated_watchdog_clock,
    prescale_if.divider pif
);

    // ------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ------------------------------------------------------------
    // The dedicated clock is slow and unrelated, so it is sampled rather than used as a clock
    logic [2:0] sync_reg;
    logic [wdt_pkg::DIV_CNT_W-1:0] div_cnt_reg;
    logic tick_reg;
    logic wd_edge;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sync_reg <= wdt_pkg::SYNC_RESET;
        end else begin
            sync_reg <= {sync_reg[1:0], i_dedicated_watchdog_clock};
        end
    end

    assign wd_edge = sync_reg[1] & ~sync_reg[2];

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_resetn || !pif.run) begin
            div_cnt_reg <= wdt_pkg::DIV_CNT_RESET;
            tick_reg <= 1'b0;
        end else if (wd_edge) begin
            if (div_cnt_reg == wdt_pkg::div_ratio_m1(pif.div_sel)) begin
                div_cnt_reg <= wdt_pkg::DIV_CNT_RESET;
                tick_reg <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
                tick_reg <= 1'b0;
            end
        end else begin
            tick_reg <= 1'b0;
        end
    end

    assign pif.tick = tick_reg;

    a_tick_single_cycle: assert property (@(posedge i_clock) disable iff (!i_resetn)
        tick_reg |=> !tick_reg)
        else $error("prescaler tick longer than one cycle");

    a_tick_on_ratio: assert property (@(posedge i_clock) disable iff (!i_resetn)
        pif.run && wd_edge && div_cnt_reg == wdt_pkg::div_ratio_m1(pif.div_sel)
        |=> tick_reg && div_cnt_reg == wdt_pkg::DIV_CNT_RESET)
        else $error("prescaler did not tick at the selected ratio");

endmodule : watchdog_prescaler

// ### sim/sys_response_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// System response side: reset, NMI and event-link receiver
// ------------------------------------------------------------
module sys_response_model (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_reset_request,
    input wire logic i_nmi_request,
    input wire logic i_event_pulse,
    output logic [7:0] o_event_count,
    output logic o_reset_seen,
    output logic o_nmi_seen
);
    // Counting cycles with the pulse high exposes a pulse that stretches
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_event_count <= 8'h00;
        end else if (i_event_pulse) begin
            o_event_count <= o_event_count + 8'h01;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_reset_seen <= 1'b0;
            o_nmi_seen <= 1'b0;
        end else begin
            o_reset_seen <= o_reset_seen | i_reset_request;
            o_nmi_seen <= o_nmi_seen | i_nmi_request;
        end
    end
endmodule : sys_response_model

// ### sim/independent_watchdog_tb.sv
`timescale 1ns/1ps
module independent_watchdog_tb;
    logic i_clock, i_resetn, wd_pin, lp_mode, refresh, nmi_sel, lp_stop;
    logic [2:0] div_sel;
    logic [1:0] tout_sel, ws_sel, we_sel;
    logic [13:0] counter;
    logic running, uf_flag, err_flag, rst_req, nmi_req, evt, rst_seen, nmi_seen;
    logic [7:0] evt_count;
    logic [15:0] status;
    logic [13:0] tops [4];
    int n_mismatch = 0;
    int samples_checked = 0;

    assign status = {9'h000, rst_seen, nmi_seen, running, uf_flag, err_flag, rst_req, nmi_req};

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    independent_watchdog i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_dedicated_watchdog_clock(wd_pin), .i_opt_div_sel(div_sel),
        .i_opt_timeout_sel(tout_sel), .i_opt_win_start_sel(ws_sel),
        .i_opt_win_end_sel(we_sel), .i_opt_nmi_select(nmi_sel),
        .i_opt_low_power_stop(lp_stop), .i_low_power_mode(lp_mode), .i_refresh(refresh),
        .o_counter(counter), .o_running(running), .o_underflow_flag(uf_flag),
        .o_refresh_error_flag(err_flag), .o_reset_request(rst_req),
        .o_nmi_request(nmi_req), .o_event_pulse(evt));

    sys_response_model i_sys (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_reset_request(rst_req), .i_nmi_request(nmi_req), .i_event_pulse(evt),
        .o_event_count(evt_count), .o_reset_seen(rst_seen), .o_nmi_seen(nmi_seen));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Options are only sampled while reset is low, so each setup needs a reset
    task automatic do_reset(input logic [2:0] d, input logic [1:0] t, input logic [1:0] ws,
                            input logic [1:0] we, input logic nmi, input logic lps);
        @(negedge i_clock);
        {div_sel, tout_sel, ws_sel, we_sel, nmi_sel, lp_stop} = {d, t, ws, we, nmi, lps};
        i_resetn = 1'b0;
        repeat (8) @(negedge i_clock);
        i_resetn = 1'b1;
        @(negedge i_clock);
    endtask : do_reset

    // Pin edges four system cycles apart, then room for the synchroniser
    task automatic pin_edges(input int n);
        repeat (n) begin
            wd_pin = 1'b1;
            repeat (2) @(negedge i_clock);
            wd_pin = 1'b0;
            repeat (2) @(negedge i_clock);
        end
        repeat (6) @(negedge i_clock);
    endtask : pin_edges

    task automatic do_refresh;
        refresh = 1'b1;
        @(negedge i_clock);
        refresh = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask : do_refresh

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Watchdog on the run itself
    // ------------------------------------------------------------
    initial begin
        #900_000;
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {i_resetn, wd_pin, lp_mode, refresh, nmi_sel, lp_stop} = 6'h00;
        {div_sel, tout_sel, ws_sel, we_sel} = 9'h000;
        tops = '{wdt_pkg::TOUT_TOP_0, wdt_pkg::TOUT_TOP_1, wdt_pkg::TOUT_TOP_2,
                 wdt_pkg::TOUT_TOP_3};
        // Low-power mode stays high here: without the stop option it must not halt
        lp_mode = 1'b1;
        for (int k = 0; k < 5; k++) begin
            do_reset(k[2:0], 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
            check(counter, wdt_pkg::TOUT_TOP_0);
            check(status, 16'h0010);
            pin_edges((16 << k) - 1);
            check(counter, wdt_pkg::TOUT_TOP_0);
            pin_edges(1);
            check(counter, wdt_pkg::TOUT_TOP_0 - 14'h0001);
        end
        for (int t = 0; t < 4; t++) begin
            do_reset(3'h0, t[1:0], 2'h0, 2'h0, 1'b0, 1'b0);
            check(counter, tops[t]);
        end
        do_reset(3'h0, 2'h0, 2'h0, 2'h3, 1'b0, 1'b1);
        pin_edges(16);
        check(counter, wdt_pkg::TOUT_TOP_0);
        lp_mode = 1'b0;
        pin_edges(16);
        check(counter, wdt_pkg::TOUT_TOP_0 - 14'h0001);
        do_refresh();
        check(counter, wdt_pkg::TOUT_TOP_0);
        do_refresh();
        check(status, 16'h0010);
        // Window start at three quarters: a refresh at the top is too early
        do_reset(3'h0, 2'h0, 2'h1, 2'h0, 1'b1, 1'b0);
        do_refresh();
        check(status, 16'h0025);
        check(evt_count, 16'h0001);
        pin_edges(16);
        check(counter, wdt_pkg::TOUT_TOP_0);
        do_refresh();
        check(evt_count, 16'h0001);
        do_reset(3'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
        check(status, 16'h0010);
        pin_edges(16 * 1023);
        check(counter, 16'h0000);
        pin_edges(16);
        check(status, 16'h004A);
        check(evt_count, 16'h0001);
        pin_edges(16);
        check(counter, 16'h0000);
        give_verdict();
    end
endmodule : independent_watchdog_tb
